// ### common/rdrc_defines.vh
`ifndef RDRC_DEFINES_VH
`define RDRC_DEFINES_VH

// Digit and value limits of the BCD ring count.
`define RDRC_BCD_ZERO 16'h0000
`define RDRC_BCD_TOP 16'h9999
`define RDRC_DIGIT_MAX 4'h9
// Range table geometry: base word index, largest variant six ranges.
`define RDRC_MAX_RANGES 6
`define RDRC_SMALL_RANGES 4
`define RDRC_TABLE_WORDS 16
`define RDRC_BASE_MAX 2'h3
// Reset value of the result word.
`define RDRC_RESULT_RST 16'h0000
// Scan divider: one scan every this many core clocks.
`define RDRC_SCAN_CYCLES 16'h0004

`endif

// ### logic/rdrc_counter.v
`include "rdrc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

// Function
// R1: The present value is a BCD ring count 0000..9999 wrapping both ways.
// R2: The value moves by one only on a scan where the count input rose.
// R3: It counts up when the direction input is low and down when high.
// R4: Range count is the configured value plus one, at most 6 (4 small); the code always walks 6 ranges (4 small).
// R5: Range k reads lower limit at base+2k+1 and upper at base+2k+2.
// R6: Lower below upper gives a true bit while the value is inside, inclusive.
// R7: Lower above upper gives a true bit while the value is outside the span.
// R8: The clear input forces the present value to 0000.
// R9: The program supplies every limit as four-digit BCD 0000..9999.
// R10: Only result bits of configured ranges are written; others are kept.
// R11: Equal limits mean a single value; clear beats a count edge.
module rdrc_counter #(
  parameter SMALL_VARIANT = 0
) (
  input wire core_clk,
  input wire sys_rst,
  input wire count_pulse_in,
  input wire up_down_select_in,
  input wire clear_in,
  input wire [1:0] range_table_base,
  input wire tbl_wr_en,
  input wire [3:0] tbl_wr_addr,
  input wire [15:0] tbl_wr_data,
  input wire res_wr_en,
  input wire [15:0] res_wr_data,
  output reg [15:0] present_value_q,
  output reg [15:0] result_word_q,
  output reg scan_done_q
);

  // *******************************************************
  // Helpers
  // *******************************************************

  // BCD increment or decrement with ring wrap.
  function [15:0] bcd_step;
    input [15:0] v;
    input down;
    integer i;
    reg carry;
    begin
      bcd_step = v;
      carry = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        if (carry) begin
          if (!down) begin
            if (v[i*4 +: 4] == `RDRC_DIGIT_MAX) begin
              bcd_step[i*4 +: 4] = 4'h0;
            end else begin
              bcd_step[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
              carry = 1'b0;
            end
          end else begin
            if (v[i*4 +: 4] == 4'h0) begin
              bcd_step[i*4 +: 4] = `RDRC_DIGIT_MAX;
            end else begin
              bcd_step[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
              carry = 1'b0;
            end
          end
        end
      end
    end
  endfunction

  // Range test; BCD order equals binary order for valid digits.
  function range_hit;
    input [15:0] pv;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (lo <= hi) begin
        range_hit = (pv >= lo) && (pv <= hi); // [R6] [R11]
      end else begin
        range_hit = (pv < hi) || (pv > lo); // [R7]
      end
    end
  endfunction

  // *******************************************************
  // Input synchronisers and scan divider
  // *******************************************************
  reg [2:0] cnt_sync_q;
  reg [2:0] dir_sync_q;
  reg [2:0] clr_sync_q;
  reg cnt_lvl_q;
  reg dir_lvl_q;
  reg clr_lvl_q;
  reg cnt_prev_q;
  reg [15:0] div_q;
  wire scan_tick;

  // Pins pass three stages; a level changes when stages two and three agree.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_sync_q <= 3'h0;
      dir_sync_q <= 3'h0;
      clr_sync_q <= 3'h0;
      cnt_lvl_q <= 1'b0;
      dir_lvl_q <= 1'b0;
      clr_lvl_q <= 1'b0;
    end else begin
      cnt_sync_q <= {cnt_sync_q[1:0], count_pulse_in};
      dir_sync_q <= {dir_sync_q[1:0], up_down_select_in};
      clr_sync_q <= {clr_sync_q[1:0], clear_in};
      if (cnt_sync_q[1] == cnt_sync_q[2]) cnt_lvl_q <= cnt_sync_q[2];
      if (dir_sync_q[1] == dir_sync_q[2]) dir_lvl_q <= dir_sync_q[2];
      if (clr_sync_q[1] == clr_sync_q[2]) clr_lvl_q <= clr_sync_q[2];
    end
  end

  assign scan_tick = (div_q == `RDRC_SCAN_CYCLES - 16'h0001);

  // The scan acts as the block's slow clock.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      div_q <= 16'h0000;
    end else if (scan_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // *******************************************************
  // Ring counter
  // *******************************************************

  // Count edge is judged against the level seen on the previous scan.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      present_value_q <= `RDRC_BCD_ZERO;
      cnt_prev_q <= 1'b0;
    end else if (scan_tick) begin
      cnt_prev_q <= cnt_lvl_q;
      if (clr_lvl_q) begin
        present_value_q <= `RDRC_BCD_ZERO; // [R8] [R11]
      end else if (cnt_lvl_q && !cnt_prev_q) begin // [R2]
        present_value_q <= bcd_step(present_value_q, dir_lvl_q); // [R1] [R3]
      end
    end
  end

  // *******************************************************
  // Range compare sequencer
  // *******************************************************
  localparam ST_IDLE = 4'b0001;
  localparam ST_LO = 4'b0010;
  localparam ST_HI = 4'b0100;
  localparam ST_DONE = 4'b1000;

  reg [3:0] state_q;
  reg [2:0] rng_q;
  reg [2:0] n_last_q;
  reg [15:0] lo_q;
  reg [15:0] pv_snap_q;
  reg [15:0] hits_q;
  reg [15:0] mask_q;
  reg [3:0] rd_addr;
  reg [2:0] rng_fetch;
  wire [15:0] rd_data;
  wire [2:0] max_last;

  assign max_last = SMALL_VARIANT ? 3'd3 : 3'd5;

  // Word address for limit k: base + 2k + 1 (lower), +2 (upper).
  // The read lands one clock late, so HI already fetches the next pair's
  // lower limit, and IDLE always points at pair zero whatever rng_q holds.
  always @* begin
    rng_fetch = rng_q;
    if (state_q == ST_IDLE) begin
      rng_fetch = 3'h0;
    end else if (state_q == ST_HI) begin
      rng_fetch = rng_q + 3'h1;
    end
    rd_addr = {2'b00, range_table_base} + {rng_fetch, 1'b0} + 4'h1; // [R5]
    if (state_q == ST_LO) begin
      rd_addr = {2'b00, range_table_base} + {rng_fetch, 1'b0} + 4'h2; // [R5]
    end
  end

  rdrc_table_mem u_mem (
    .core_clk(core_clk),
    .wr_en(tbl_wr_en),
    .wr_addr(tbl_wr_addr),
    .wr_data(tbl_wr_data),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data)
  );

  // Walks all six ranges (four small) once every four scans (three small); the base word is never read.
  // Reads are pipelined by one clock, so IDLE primes the first lower limit.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      rng_q <= 3'h0;
      n_last_q <= 3'h0;
      lo_q <= 16'h0000;
      pv_snap_q <= 16'h0000;
      hits_q <= 16'h0000;
      mask_q <= 16'h0000;
      result_word_q <= `RDRC_RESULT_RST;
      scan_done_q <= 1'b0;
    end else begin
      scan_done_q <= 1'b0;
      if (res_wr_en) begin
        result_word_q <= res_wr_data;
      end
      case (state_q)
        ST_IDLE: begin
          rng_q <= 3'h0;
          hits_q <= 16'h0000;
          mask_q <= 16'h0000;
          if (scan_tick) begin
            pv_snap_q <= present_value_q;
            state_q <= ST_LO;
          end
        end
        ST_LO: begin
          lo_q <= rd_data;
          state_q <= ST_HI;
        end
        ST_HI: begin
          hits_q[rng_q] <= range_hit(pv_snap_q, lo_q, rd_data);
          mask_q[rng_q] <= 1'b1;
          if (rng_q >= n_last_q || rng_q >= max_last) begin // [R4]
            state_q <= ST_DONE;
          end else begin
            rng_q <= rng_q + 3'h1;
            state_q <= ST_LO;
          end
        end
        ST_DONE: begin
          // Untouched bits keep program data. [R10]
          result_word_q <= (result_word_q & ~mask_q) | (hits_q & mask_q);
          scan_done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // Range count is fixed: last index 3'd5, not read from the base word.
      n_last_q <= 3'd5;
    end
  end

endmodule // rdrc_counter

`default_nettype wire

// ### logic/rdrc_table_mem.v
`timescale 1ns/10ps
`default_nettype none

// *********************************************************
// Range table memory: one write port, one registered read.
// *********************************************************
module rdrc_table_mem (
  input wire core_clk,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [15:0] wr_data,
  input wire [3:0] rd_addr,
  output reg [15:0] rd_data_q
);

  reg [15:0] mem_q [0:15];

  // Writes land at once; reads come out one clock later.
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end

endmodule // rdrc_table_mem

`default_nettype wire

// ### verif/rdrc_counter_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench: counter against an integer model.
// ****
module rdrc_counter_bench;
  logic core_clk = 0, sys_rst = 1, count_pulse_in = 0, clear_in = 0;
  logic up_down_select_in = 0, res_wr_en = 0, load = 0;
  logic [1:0] range_table_base = 2'h2;
  logic [2:0] idx = 3'h0;
  logic [15:0] res_wr_data = 16'h0000, p_lo, p_hi, upper = 16'h0000;
  logic tbl_wr_en, scan_done_q;
  logic [3:0] tbl_wr_addr;
  logic [15:0] tbl_wr_data, present_value_q, result_word_q;
  int errors = 0, n_compared = 0, pv = 0, cyc = 0, k;
  int seed = 32'h22c61d4f;
  int lo[6] = '{1, 4, 3, 9998, 0, 0}, hi[6] = '{2, 2, 3, 1, 0, 0};
  int ops[17] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 3, 2};
  rdrc_counter i_dut (.*);
  rdrc_prog_model i_prog (.*);
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] bcd(int v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // Model the six ranges; a reversed pair flags the outside span.
  task automatic check_all();
    logic [15:0] r;
    r = upper;
    for (int j = 0; j < 6; j++)
      r[j] = lo[j] <= hi[j] ? pv >= lo[j] && pv <= hi[j]
                            : pv < hi[j] || pv > lo[j];
    chk("value", present_value_q, bcd(pv));
    chk("result", result_word_q, r);
  endtask
  // Kinds: 0 up, 1 down, 2 clear, 3 clear with a count edge.
  task automatic op(int kind);
    @(posedge core_clk);
    up_down_select_in <= kind == 1;
    clear_in <= kind > 1;
    repeat (12) @(posedge core_clk);
    count_pulse_in <= kind != 2;
    repeat (12) @(posedge core_clk);
    count_pulse_in <= 0;
    clear_in <= 0;
    repeat (40) @(posedge core_clk); // Outlasts a compare that just missed.
    pv = kind > 1 ? 0 : (pv + (kind == 1 ? 9999 : 1)) % 10000;
    check_all();
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cut a hang short well past the expected run length.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    chk("rst value", present_value_q, 16'h0000);
    chk("rst result", result_word_q, 16'h0000);
    for (k = 0; k < 6; k++) begin
      if (k > 3) lo[k] = $unsigned($random(seed)) % 10000;
      if (k > 3) hi[k] = $unsigned($random(seed)) % 10000;
      @(posedge core_clk);
      idx <= 3'(k);
      p_lo <= bcd(lo[k]);
      p_hi <= bcd(hi[k]);
      load <= 1;
      @(posedge core_clk);
      load <= 0;
      repeat (2) @(posedge core_clk);
    end
    // Write spare bits just after a compare so the two never collide.
    for (k = 0; k < 60 && scan_done_q !== 1'b1; k++) @(posedge core_clk);
    chk("done seen", {15'h0000, scan_done_q}, 16'h0001);
    upper = 16'($random(seed)) | 16'hFFC0;
    res_wr_data <= upper;
    res_wr_en <= 1;
    @(posedge core_clk);
    res_wr_en <= 0;
    foreach (ops[j]) op(ops[j]);
    repeat (10) op($unsigned($random(seed)) % 4);
    give_verdict();
  end
endmodule // rdrc_counter_bench
`default_nettype wire

// ### verif/rdrc_counter_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker.
// ****
module rdrc_chk #(parameter SMALL_VARIANT = 0) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic count_pulse_in,
  input wire logic up_down_select_in,
  input wire logic clear_in,
  input wire logic [1:0] range_table_base,
  input wire logic tbl_wr_en,
  input wire logic [3:0] tbl_wr_addr,
  input wire logic [15:0] tbl_wr_data,
  input wire logic res_wr_en,
  input wire logic [15:0] res_wr_data,
  input wire logic [15:0] present_value_q,
  input wire logic [15:0] result_word_q,
  input wire logic scan_done_q
);
  localparam int NR = SMALL_VARIANT ? 4 : 6;
  wire [15:0] pv = present_value_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Weigh the digits so that one step reads as a difference of one.
  function automatic int val(logic [15:0] v);
    return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction
  a_digits_bcd: assert property (
    pv[15:12] < 10 && pv[11:8] < 10 && pv[7:4] < 10 && pv[3:0] < 10)
    else $error("value digit above nine");
  a_step_one: assert property ($changed(pv) |-> pv == 0 ||
    (val(pv) + 10000 - val($past(pv))) % 10000 inside {1, 9999})
    else $error("value moved by more than one");
  a_reset_zero: assert property ($fell(sys_rst) |->
    pv == 0 && result_word_q == 0) else $error("outputs not zero");
  // Pin sync and scan wait add up to eight clocks, so ten is safe.
  a_clear_wins: assert property (
    clear_in [*8] ##1 clear_in ##1 clear_in |-> pv == 0)
    else $error("clear did not hold value at zero");
  a_idle_still: assert property (
    (!count_pulse_in && !clear_in) [*8] |-> $stable(pv))
    else $error("value moved without a count edge");
  a_upper_kept: assert property (
    $changed(result_word_q[15:NR]) |-> $past(res_wr_en))
    else $error("spare result bits overwritten");
  a_result_cause: assert property (
    $changed(result_word_q) |-> scan_done_q || $past(res_wr_en))
    else $error("result changed outside a compare");
  a_done_pulse: assert property (scan_done_q |=> !scan_done_q)
    else $error("done pulse longer than one cycle");
  c_done: cover property (scan_done_q);
  c_top: cover property ($changed(pv) && pv == 16'h9999);
  c_outside: cover property (result_word_q[1]);
endmodule // rdrc_chk
bind rdrc_counter rdrc_chk #(.SMALL_VARIANT(SMALL_VARIANT)) i_chk (.*);
`default_nettype wire

// ### verif/rdrc_prog_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Program side: loads one limit pair per request.
// ****
module rdrc_prog_model (
  input wire logic core_clk,
  input wire logic [1:0] range_table_base,
  input wire logic load,
  input wire logic [2:0] idx,
  input wire logic [15:0] p_lo,
  input wire logic [15:0] p_hi,
  output logic tbl_wr_en,
  output logic [3:0] tbl_wr_addr,
  output logic [15:0] tbl_wr_data
);
  logic hi_q = 1'b0;
  // Lower limit first, upper next; idle data toggles so stale words show.
  always @(posedge core_clk) begin
    tbl_wr_en <= load | hi_q;
    hi_q <= load;
    if (load) begin
      tbl_wr_addr <= 4'(range_table_base + 2 * idx + 1);
      tbl_wr_data <= p_lo;
    end else if (hi_q) begin
      tbl_wr_addr <= tbl_wr_addr + 4'h1;
      tbl_wr_data <= p_hi;
    end else begin
      tbl_wr_data <= ~tbl_wr_data;
    end
  end
endmodule // rdrc_prog_model
`default_nettype wire
